// ---- core/hlt_pkg.sv ----
// Package: register map, mode encodings and timing constants of the limit timer
`default_nettype none
package hlt_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] OFS_CTRL    = 4'h0;  // Run bit and sleep sync bit
  localparam logic [3:0] OFS_MODE    = 4'h4;  // Mode field in bits 4:0
  localparam logic [3:0] OFS_PERIOD  = 4'h8;  // Period register
  localparam logic [3:0] OFS_COUNT   = 4'hC;  // Count register, read only
  localparam logic [3:0] OFS_WIDTH   = 4'h0;  // Offset within second page
  localparam logic [3:0] OFS_STATUS  = 4'h4;  // Sticky events, write one to clear
  localparam logic [3:0] OFS_MASK    = 4'h8;  // Interrupt mask
  localparam logic [3:0] OFS_DRIVE   = 4'hC;  // PWM drive readback
  // Field positions
  localparam int RUN_BIT    = 0;
  localparam int SYNC_BIT   = 1;
  localparam int MODE_MSB   = 4;
  localparam int EV_MATCH   = 0;
  localparam int EV_START   = 1;
  localparam int EV_EXTRST  = 2;
  // Reset values
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] WIDTH_RST  = 8'h00;
  localparam logic [4:0] MODE_RST   = 5'h00;
  // Mode encodings
  localparam logic [4:0] M_EHL_RISE  = 5'h0C;
  localparam logic [4:0] M_EHL_FALL  = 5'h0D;
  localparam logic [4:0] M_LRE_LOW   = 5'h0E;
  localparam logic [4:0] M_LRE_HIGH  = 5'h0F;
  localparam logic [4:0] M_MONO_RISE = 5'h11;
  localparam logic [4:0] M_MONO_FALL = 5'h12;
  localparam logic [4:0] M_MONO_BOTH = 5'h13;
  localparam logic [4:0] M_LHL_LOW   = 5'h16;
  localparam logic [4:0] M_LHL_HIGH  = 5'h17;
  // Timing: restart delay after a reset edge, in timer clocks
  localparam logic [1:0] RESTART_CLKS = 2'h2;
endpackage
`default_nettype wire

// ---- core/hw_limit_timer.sv ----
// Hardware limit timer: one-shot, monostable and level-reset modes with PWM drive
`default_nettype none
module hw_limit_timer
(
  input  wire  logic        clk_i,       // Timer clock, 125 MHz
  input  wire  logic        rst_i,       // Synchronous reset, active high
  input  wire  logic [4:0]  adr_i,       // Wishbone byte address
  input  wire  logic [31:0] dat_i,       // Wishbone write data
  output logic       [31:0] dat_o,       // Wishbone read data
  input  wire  logic        we_i,        // Write enable
  input  wire  logic [3:0]  sel_i,       // Byte selects
  input  wire  logic        cyc_i,       // Bus cycle
  input  wire  logic        stb_i,       // Strobe
  output logic              ack_o,       // Acknowledge
  input  wire  logic        ext_reset_input_i, // External reset source
  input  wire  logic        sleep_i,     // Processor in sleep
  output logic              pwm_drive_o, // PWM drive level
  output logic              pwm_set_pulse_o,   // One-cycle drive start
  output logic              postscaled_match_out_o, // Period match pulse
  output logic [7:0]        count_value_o,     // Current count
  output logic              irq_o        // Level interrupt
);

  // ********************************************************
  // Register state
  // ********************************************************
  logic       run;                // Run bit, hardware clears it
  logic       prescaler_out_sync; // Sleep freeze select
  logic [4:0] mode;               // Mode field
  logic [7:0] period_register;    // Period value
  logic [7:0] pulse_width_compare; // Drive end compare
  logic [7:0] count_register;     // Counter
  logic [2:0] status;             // Sticky events
  logic [2:0] mask;               // Interrupt mask

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic req;        // Live request not yet answered
  logic wr;         // Write taken this cycle
  logic page;       // Upper register page
  logic [3:0] ofs;  // Offset in page
  assign req  = cyc_i && stb_i && !ack_o;
  assign wr   = req && we_i && sel_i[0];
  assign page = adr_i[4];
  assign ofs  = adr_i[3:0];

  logic wr_ctrl;    // Write to control
  assign wr_ctrl = wr && !page && (ofs == hlt_pkg::OFS_CTRL);

  // Ack one cycle after request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // ********************************************************
  // External input synchroniser and detectors
  // ********************************************************
  logic ers_meta;  // First stage, only read by second
  logic ers_sync;  // Synchronised level
  logic ers_prev;  // Previous synchronised level
  // Two stages keep edge detection to one event per transition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ers_meta <= 1'b0;
      ers_sync <= 1'b0;
      ers_prev <= 1'b0;
    end
    else
    begin
      ers_meta <= ext_reset_input_i;
      ers_sync <= ers_meta;
      ers_prev <= ers_sync;
    end
  end

  logic rise;       // Rising edge
  logic fall;       // Falling edge
  assign rise = ers_sync && !ers_prev;
  assign fall = !ers_sync && ers_prev;

  // Mode decode
  logic is_ehl;     // Edge hardware limit one-shot
  logic is_lre;     // Level reset, edge start one-shot
  logic is_mono;    // Monostable
  logic is_lhl;     // Level hardware limit one-shot
  logic edge_q;     // Qualifying edge for this mode
  logic in_reset;   // Input at reset level
  always_comb
  begin
    is_ehl   = 1'b0;
    is_lre   = 1'b0;
    is_mono  = 1'b0;
    is_lhl   = 1'b0;
    edge_q   = 1'b0;
    in_reset = 1'b0;
    case (mode)
      hlt_pkg::M_EHL_RISE:  begin is_ehl = 1'b1; edge_q = rise; end
      hlt_pkg::M_EHL_FALL:  begin is_ehl = 1'b1; edge_q = fall; end
      hlt_pkg::M_LRE_LOW:   begin is_lre = 1'b1; edge_q = rise; in_reset = !ers_sync; end
      hlt_pkg::M_LRE_HIGH:  begin is_lre = 1'b1; edge_q = fall; in_reset = ers_sync; end
      hlt_pkg::M_MONO_RISE: begin is_mono = 1'b1; edge_q = rise; end
      hlt_pkg::M_MONO_FALL: begin is_mono = 1'b1; edge_q = fall; end
      hlt_pkg::M_MONO_BOTH: begin is_mono = 1'b1; edge_q = rise || fall; end
      hlt_pkg::M_LHL_LOW:   begin is_lhl = 1'b1; in_reset = !ers_sync; end
      hlt_pkg::M_LHL_HIGH:  begin is_lhl = 1'b1; in_reset = ers_sync; end
      default:              begin end
    endcase
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  typedef enum logic [3:0]
  {
    ST_ARMED = 4'h1,  // Run set, waiting for start condition
    ST_COUNT = 4'h2,  // Counting
    ST_HOLD  = 4'h4,  // Reset edge seen, restart pending
    ST_DONE  = 4'h8   // Monostable halted at period
  } seq_t;
  seq_t state;
  seq_t next_state;
  logic [1:0] hold_cnt;   // Restart delay counter
  logic frozen;           // Sleep freeze
  logic match;            // Count equals period
  logic start;            // Timer starts this cycle
  logic hold_done;        // Restart delay over

  assign frozen    = sleep_i && prescaler_out_sync;
  assign match     = (count_register == period_register);
  assign hold_done = (hold_cnt == hlt_pkg::RESTART_CLKS - 2'h1);

  // Start condition of the armed state per mode
  always_comb
  begin
    start = 1'b0;
    if (state == ST_ARMED && run)
    begin
      if (is_lhl)
        start = !in_reset;
      else if (is_lre)
        start = edge_q;
      else
        start = edge_q;
    end
  end

  // Next state; edges and level reset only matter while running
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_ARMED: if (start) next_state = ST_COUNT;
      ST_COUNT:
      begin
        if (is_ehl && edge_q)
          next_state = ST_HOLD;
        else if ((is_lre || is_lhl) && in_reset)
          next_state = ST_ARMED;
        else if (match && is_mono)
          next_state = ST_DONE;
        else if (match)
          next_state = ST_ARMED;
      end
      ST_HOLD:
      begin
        if (is_ehl && edge_q)
          next_state = ST_HOLD;
        else if (hold_done)
          next_state = ST_COUNT;
      end
      ST_DONE: next_state = ST_DONE;
    endcase
    if (!run)
      next_state = ST_ARMED;
  end

  // State register, frozen during sleep while the sync bit is set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_ARMED;
    else if (!frozen)
      state <= next_state;
  end

  // Restart delay counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_cnt <= 2'h0;
    else if (frozen)
      hold_cnt <= hold_cnt;
    else if (state != ST_HOLD || edge_q)
      hold_cnt <= 2'h0;
    else
      hold_cnt <= hold_cnt + 2'h1;
  end

  // Counter: clears after match in every mode and when armed with run off, holds otherwise when idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_register <= 8'h00;
    else if (frozen)
      count_register <= count_register;
    else if (state == ST_COUNT && is_ehl && edge_q)
      count_register <= 8'h00;
    else if ((is_lre || is_lhl) && in_reset)
      count_register <= 8'h00;
    else if (state == ST_COUNT && match)
      count_register <= 8'h00;
    else if (state == ST_COUNT)
      count_register <= count_register + 8'h01;
    else if (state == ST_ARMED && !run)
      count_register <= 8'h00;
  end

  // Limitation: a match is the only period event; idle states see none
  logic match_ev;    // Period match while counting
  assign match_ev = !frozen && state == ST_COUNT && match && run;

  // ********************************************************
  // Run bit and control registers
  // ********************************************************
  // Hardware clear on match wins over a same-cycle software write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run <= 1'b0;
    else if (match_ev && !is_mono)
      run <= 1'b0;
    else if (wr_ctrl)
      run <= dat_i[hlt_pkg::RUN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescaler_out_sync  <= 1'b0;
      mode                <= hlt_pkg::MODE_RST;
      period_register     <= hlt_pkg::PERIOD_RST;
      pulse_width_compare <= hlt_pkg::WIDTH_RST;
      mask                <= 3'h0;
    end
    else if (wr)
    begin
      if (!page && ofs == hlt_pkg::OFS_CTRL)
        prescaler_out_sync <= dat_i[hlt_pkg::SYNC_BIT];
      if (!page && ofs == hlt_pkg::OFS_MODE)
        mode <= dat_i[hlt_pkg::MODE_MSB:0];
      if (!page && ofs == hlt_pkg::OFS_PERIOD)
        period_register <= dat_i[7:0];
      if (page && ofs == hlt_pkg::OFS_WIDTH)
        pulse_width_compare <= dat_i[7:0];
      if (page && ofs == hlt_pkg::OFS_MASK)
        mask <= dat_i[2:0];
    end
  end

  // ********************************************************
  // PWM drive
  // ********************************************************
  logic drv_set;     // Drive start event
  logic drv_clr;     // Compare match
  // Match restarts never set the drive; only start or reset edges
  assign drv_set = !frozen && (start || (state == ST_COUNT && is_ehl && edge_q));
  assign drv_clr = !frozen && state == ST_COUNT && count_register == pulse_width_compare;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwm_drive_o <= 1'b0;
    else if (drv_set)
      pwm_drive_o <= 1'b1;
    else if (drv_clr)
      pwm_drive_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_set_pulse_o        <= 1'b0;
      postscaled_match_out_o <= 1'b0;
    end
    else
    begin
      pwm_set_pulse_o        <= drv_set;
      postscaled_match_out_o <= match_ev;
    end
  end
  assign count_value_o = count_register;

  // ********************************************************
  // Interrupts
  // ********************************************************
  logic [2:0] ev;    // Event vector
  assign ev = {drv_set && state == ST_COUNT, start, match_ev};
  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 3'h0;
    else if (wr && page && ofs == hlt_pkg::OFS_STATUS)
      status <= (status & ~dat_i[2:0]) | ev;
    else
      status <= status | ev;
  end
  assign irq_o = |(status & mask);

  // Read mux, unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (req && !we_i)
    begin
      dat_o <= 32'h0000_0000;
      unique case ({page, ofs})
        {1'b0, hlt_pkg::OFS_CTRL}:   dat_o[1:0] <= {prescaler_out_sync, run};
        {1'b0, hlt_pkg::OFS_MODE}:   dat_o[4:0] <= mode;
        {1'b0, hlt_pkg::OFS_PERIOD}: dat_o[7:0] <= period_register;
        {1'b0, hlt_pkg::OFS_COUNT}:  dat_o[7:0] <= count_register;
        {1'b1, hlt_pkg::OFS_WIDTH}:  dat_o[7:0] <= pulse_width_compare;
        {1'b1, hlt_pkg::OFS_STATUS}: dat_o[2:0] <= status;
        {1'b1, hlt_pkg::OFS_MASK}:   dat_o[2:0] <= mask;
        {1'b1, hlt_pkg::OFS_DRIVE}:  dat_o[0]   <= pwm_drive_o;
        default:                     dat_o      <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence reset_edge_s;
    state == ST_COUNT && is_ehl && edge_q && !frozen && run;
  endsequence

  restart_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_edge_s ##1 (!edge_q && !frozen && run && is_ehl)[*2] |=> state == ST_COUNT)
    else $error("restart not two clocks after reset edge");
  match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_ev && !is_mono |=> !run && count_register == 8'h00)
    else $error("period match did not clear run and count");
  edge_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_edge_s |=> pwm_drive_o && pwm_set_pulse_o)
    else $error("reset edge did not set drive");
  level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_lre || is_lhl) && in_reset && !frozen |=> count_register == 8'h00)
    else $error("count not held at reset level");
  mono_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_ev && is_mono && !frozen && !wr_ctrl |=> state == ST_DONE && run)
    else $error("monostable did not stop at match");
  no_match_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_ev && !pwm_drive_o && !drv_set |=> !pwm_drive_o)
    else $error("drive set at period match");
  level_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_ARMED && is_lhl && run && !in_reset && !frozen |=> state == ST_COUNT && pwm_drive_o)
    else $error("level one-shot did not start");
  sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frozen |=> $stable(count_register))
    else $error("count moved in sleep with sync set");
  wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_COUNT && match && !frozen |=> count_register == 8'h00)
    else $error("count not cleared after period match");
endmodule
`default_nettype wire

// ---- test/hlt_far_side.sv ----
// Far-side model: external reset source with a settable lag, and a tally of drive starts
`default_nettype none
module hlt_far_side
(
  input  wire logic clk_i,       // Timer clock
  input  wire logic level_i,     // Level the source is told to take
  input  wire logic slow_i,      // Four clocks of lag instead of one
  input  wire logic set_pulse_i, // Drive start pulse from the timer
  output logic      ext_o,       // Pin into the timer
  output var int    starts_o     // Drive starts seen so far
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pipe = 4'h0;       // Lag line; a slow source stresses the input synchroniser

  // ****************************************
  // Source lag and start tally
  // ****************************************
  // Edges leave the source only on the clock, never mid-cycle
  always @(posedge clk_i)
  begin
    pipe <= {pipe[2:0], level_i};
    starts_o <= starts_o + int'(set_pulse_i === 1'b1);
  end
  assign ext_o = slow_i ? pipe[3] : pipe[0];
endmodule
`default_nettype wire

// ---- test/hw_limit_timer_test.sv ----
// Testbench: limit timer modes, register access, interrupt and sleep behaviour
`default_nettype none
module hw_limit_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [4:0] mode; logic idle; logic run_after; } row_t;
  localparam logic [4:0] A_CTRL = {1'b0, hlt_pkg::OFS_CTRL};
  localparam logic [4:0] A_MODE = {1'b0, hlt_pkg::OFS_MODE};
  localparam logic [4:0] A_PER  = {1'b0, hlt_pkg::OFS_PERIOD};
  localparam logic [4:0] A_CNT  = {1'b0, hlt_pkg::OFS_COUNT};
  localparam logic [4:0] A_WID  = {1'b1, hlt_pkg::OFS_WIDTH};
  localparam logic [4:0] A_STAT = {1'b1, hlt_pkg::OFS_STATUS};
  localparam logic [4:0] A_MASK = {1'b1, hlt_pkg::OFS_MASK};
  localparam logic [4:0] A_DRV  = {1'b1, hlt_pkg::OFS_DRIVE};
  logic        clk_i = 1'b0;     // 125 MHz clock
  logic        rst_i = 1'b1;     // Synchronous reset
  logic [4:0]  adr_i = 5'h00;    // Bus request lines
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        level = 1'b0;     // Commanded external level
  logic        slow = 1'b0;      // Source lag select
  logic        sleep_i = 1'b0;   // Processor sleep
  logic [31:0] dat_o;
  logic        ack_o, ext_wire, pwm_drive_o, pwm_set_pulse_o, postscaled_match_out_o, irq_o;
  logic [7:0]  count_value_o;
  logic [7:0]  c1;               // Snapshot of the count
  logic [31:0] rd;               // Last read data
  int          starts, s0, err_count, cmp_count;
  // Ordinary cases: one row per mode except M_LHL_HIGH, idle level, run bit expected after the match
  row_t        rows [8] = '{'{hlt_pkg::M_EHL_RISE, 1'b0, 1'b0}, '{hlt_pkg::M_EHL_FALL, 1'b1, 1'b0},
                            '{hlt_pkg::M_LRE_LOW, 1'b0, 1'b0}, '{hlt_pkg::M_LRE_HIGH, 1'b1, 1'b0},
                            '{hlt_pkg::M_MONO_RISE, 1'b0, 1'b1}, '{hlt_pkg::M_MONO_FALL, 1'b1, 1'b1},
                            '{hlt_pkg::M_MONO_BOTH, 1'b0, 1'b1}, '{hlt_pkg::M_LHL_LOW, 1'b0, 1'b0}};

  always #4 clk_i = ~clk_i;

  hw_limit_timer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .ext_reset_input_i(ext_wire),
    .sleep_i(sleep_i), .pwm_drive_o(pwm_drive_o), .pwm_set_pulse_o(pwm_set_pulse_o),
    .postscaled_match_out_o(postscaled_match_out_o), .count_value_o(count_value_o), .irq_o(irq_o));
  hlt_far_side far (.clk_i(clk_i), .level_i(level), .slow_i(slow), .set_pulse_i(pwm_set_pulse_o),
    .ext_o(ext_wire), .starts_o(starts));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: hit = count_value_o !== 8'h00;
      1: hit = postscaled_match_out_o === 1'b1;
      default: hit = count_value_o === 8'h00;
    endcase
  endfunction

  // Bounded wait: 0 count running, 1 period match, 2 count cleared
  task automatic await(input int sel, input string nm);
    int n;
    n = 0;
    while (n < 100 && !hit(sel))
    begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, 32'h1, {31'h0, n < 100});
  endtask

  // Arms a mode with the source parked at a level
  task automatic arm(input logic [4:0] m, input logic [7:0] p, input logic lv);
    wb(1'b1, A_MODE, {27'h0, m});
    wb(1'b1, A_PER, {24'h0, p});
    level <= lv;
    repeat (8) @(posedge clk_i);
    s0 = starts;
  endtask

  task automatic give_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl reset", A_CTRL, 32'h0);
    rdc("period reset", A_PER, {24'h0, hlt_pkg::PERIOD_RST});
    rdc("mode reset", A_MODE, {27'h0, hlt_pkg::MODE_RST});
    rdc("drive reset", A_DRV, 32'h0);
    rdc("unmapped", 5'h02, 32'h0);
    wb(1'b1, A_CNT, 32'h5);
    rdc("count read only", A_CNT, 32'h0);
    wb(1'b1, A_MODE, 32'hFF);
    rdc("mode width", A_MODE, 32'h1F);
    wb(1'b1, A_WID, 32'h1);
    // Table of modes: start, match, run bit, drive
    foreach (rows[i])
    begin
      slow <= i[0];
      arm(rows[i].mode, 8'h03, rows[i].idle);
      wb(1'b1, A_CTRL, 32'h1);
      level <= ~rows[i].idle;
      await(0, "start");
      await(1, "match");
      repeat (2) @(posedge clk_i);
      chk("count after match", 32'h0, {24'h0, count_value_o});
      chk("drive after match", 32'h0, {31'h0, pwm_drive_o});
      chk("drive starts", 32'h1, 32'(starts - s0));
      rdc("run after match", A_CTRL, {31'h0, rows[i].run_after});
      rdc("status", A_STAT, 32'h3);
      wb(1'b1, A_CTRL, 32'h0);
      wb(1'b1, A_STAT, 32'h7);
    end
    slow <= 1'b0;
    // Later edges reset and restart; edges ignored after the match
    arm(hlt_pkg::M_EHL_RISE, 8'h28, 1'b0);
    wb(1'b1, A_CTRL, 32'h1);
    level <= 1'b1;
    await(0, "first edge start");
    repeat (6) @(posedge clk_i);
    level <= 1'b0;
    repeat (4) @(posedge clk_i);
    level <= 1'b1;
    await(2, "reset edge");
    await(0, "resume");
    chk("restart drive", 32'h2, 32'(starts - s0));
    await(1, "match");
    level <= 1'b0;
    repeat (4) @(posedge clk_i);
    level <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("edge ignored", 32'h0, {24'h0, count_value_o});
    rdc("status events", A_STAT, 32'h7);
    wb(1'b1, A_STAT, 32'h7);
    // Level one-shot started by the run bit, input already released
    arm(hlt_pkg::M_LHL_HIGH, 8'h03, 1'b0);
    wb(1'b1, A_CTRL, 32'h1);
    await(0, "run starts");
    await(1, "match");
    repeat (10) @(posedge clk_i);
    chk("held after match", 32'h0, {24'h0, count_value_o});
    chk("run start drive", 32'h1, 32'(starts - s0));
    rdc("run cleared", A_CTRL, 32'h0);
    // Level reset, edge start: active level alone does not start
    arm(hlt_pkg::M_LRE_LOW, 8'h03, 1'b1);
    wb(1'b1, A_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    chk("needs new edge", 32'h0, {24'h0, count_value_o});
    level <= 1'b0;
    repeat (4) @(posedge clk_i);
    level <= 1'b1;
    await(0, "edge after run");
    await(1, "match");
    // Monostable: extra edges while counting leave the drive alone
    // Wide compare so the drive stands long enough to be seen high
    wb(1'b1, A_WID, 32'h20);
    wb(1'b1, A_STAT, 32'h7);
    arm(hlt_pkg::M_MONO_BOTH, 8'h3C, 1'b0);
    wb(1'b1, A_CTRL, 32'h1);
    level <= 1'b1;
    await(0, "mono start");
    chk("drive active", 32'h1, {31'h0, pwm_drive_o});
    rdc("drive readback", A_DRV, 32'h1);
    repeat (8) @(posedge clk_i);
    level <= 1'b0;
    repeat (8) @(posedge clk_i);
    level <= 1'b1;
    await(1, "mono match");
    chk("drive at mono match", 32'h0, {31'h0, pwm_drive_o});
    chk("extra edges", 32'h1, 32'(starts - s0));
    wb(1'b1, A_CTRL, 32'h0);
    // Interrupt: masked start event, write one to clear
    wb(1'b1, A_MASK, 32'h2);
    chk("irq start", 32'h1, {31'h0, irq_o});
    wb(1'b1, A_STAT, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wb(1'b1, A_MASK, 32'h1);
    chk("irq match", 32'h1, {31'h0, irq_o});
    wb(1'b1, A_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    // Sleep with and without output sync
    arm(hlt_pkg::M_LHL_HIGH, 8'hC8, 1'b0);
    wb(1'b1, A_CTRL, 32'h3);
    await(0, "sleep run");
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    c1 = count_value_o;
    repeat (10) @(posedge clk_i);
    chk("frozen in sleep", {24'h0, c1}, {24'h0, count_value_o});
    wb(1'b1, A_CTRL, 32'h1);
    c1 = count_value_o;
    repeat (5) @(posedge clk_i);
    chk("runs in sleep", 32'h1, {31'h0, count_value_o > c1});
    sleep_i <= 1'b0;
    // Reset in mid-run, while the count is moving and the drive may stand
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("count after mid reset", 32'h0, {24'h0, count_value_o});
    chk("drive after mid reset", 32'h0, {31'h0, pwm_drive_o});
    rdc("ctrl after mid reset", A_CTRL, 32'h0);
    rdc("period after mid reset", A_PER, {24'h0, hlt_pkg::PERIOD_RST});
    wb(1'b1, A_CTRL, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
